// ==== src/bcdo_port.sv ====
// Output and handshake side of a parallel BCD port, AXI4-Lite slave.
// Assumes the peripheral flag lines are asynchronous; they are synchronised here.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module bcdo_port (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral pins
  output logic [7:0] data_out,
  output logic request_line_a,
  output logic request_line_b,
  output logic peripheral_reset_n,
  input wire logic [1:0] peripheral_flag_lines,
  input wire logic [39:0] digit_inputs,
  input wire logic first_sign_input,
  input wire logic second_sign_input,
  input wire logic overrange_input,
  // Interrupt
  output logic irq
);

  // Synchronisers for flags and inputs
  logic [1:0] flag_s1_reg, flag_s2_reg, flag_prev_reg;
  bcdo_pkg::bcdo_inputs_s in_s1_reg, in_s2_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_s1_reg <= 2'h0;
      flag_s2_reg <= 2'h0;
      flag_prev_reg <= 2'h0;
      in_s1_reg <= '0;
      in_s2_reg <= '0;
    end
    else
    begin
      flag_s1_reg <= peripheral_flag_lines;
      flag_s2_reg <= flag_s1_reg;
      flag_prev_reg <= flag_s2_reg;
      in_s1_reg <= {digit_inputs, first_sign_input, second_sign_input, overrange_input};
      in_s2_reg <= in_s1_reg;
    end
  end

  // Register state
  logic [7:0] data_out_reg, data_out_next;
  logic [31:0] timeout_reg, timeout_next;
  logic [1:0] edge_sel_reg, edge_sel_next;
  logic ready_reg, ready_next;
  logic [1:0] req_reg, req_next;
  bcdo_pkg::bcdo_inputs_s cap_reg, cap_next;
  logic [1:0] ev_reg, ev_next;
  logic [1:0] ev_en_reg, ev_en_next;
  logic [31:0] tcnt_reg, tcnt_next;
  logic [31:0] pcnt_reg, pcnt_next;
  bcdo_pkg::bcdo_state_e state_reg, state_next;

  // AXI handshake state
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next, bvalid_reg, bvalid_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next, bresp_reg, bresp_next;

  logic wr_fire, rd_fire, wr_hit;
  logic [1:0] flag_rise, flag_fall, clr_evt;
  logic flags_idle;
  logic [1:0] ev_set;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Flag edges; each channel's switch picks the clearing edge
  assign flag_rise = flag_s2_reg & ~flag_prev_reg;
  assign flag_fall = ~flag_s2_reg & flag_prev_reg;
  assign clr_evt = (edge_sel_reg & flag_rise) | (~edge_sel_reg & flag_fall);
  assign flags_idle = (flag_s2_reg == 2'b00);

  // Next-state logic for registers, handshake and bus
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    data_out_next = data_out_reg;
    timeout_next = timeout_reg;
    edge_sel_next = edge_sel_reg;
    ready_next = ready_reg;
    req_next = req_reg;
    cap_next = cap_reg;
    ev_next = ev_reg;
    ev_en_next = ev_en_reg;
    tcnt_next = tcnt_reg;
    pcnt_next = pcnt_reg;
    state_next = state_reg;
    wr_hit = 1'b1;
    ev_set = 2'b00;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    // Handshake sequence
    case (state_reg)
      bcdo_pkg::ST_IDLE:
        tcnt_next = 32'h0;
      bcdo_pkg::ST_REQ:
      begin
        tcnt_next = tcnt_reg + 32'h1;
        req_next = req_reg & ~clr_evt;
        if (req_next == 2'b00)
          state_next = bcdo_pkg::ST_WAIT_READY;
      end
      bcdo_pkg::ST_WAIT_READY:
      begin
        tcnt_next = tcnt_reg + 32'h1;
        if (flags_idle)
        begin
          state_next = bcdo_pkg::ST_IDLE;
          ready_next = 1'b1;
          ev_set[bcdo_pkg::EV_READY] = 1'b1;
          cap_next = in_s2_reg;
        end
      end
      bcdo_pkg::ST_PRESET:
      begin
        pcnt_next = pcnt_reg - 32'h1;
        if (pcnt_reg == 32'h1)
        begin
          state_next = bcdo_pkg::ST_IDLE;
          req_next = 2'b00;
        end
      end
      default:
        state_next = bcdo_pkg::ST_IDLE;
    endcase
    // Timeout supervision, zero limit disables
    if ((state_reg == bcdo_pkg::ST_REQ || state_reg == bcdo_pkg::ST_WAIT_READY)
        && timeout_reg != 32'h0 && tcnt_reg >= timeout_reg)
    begin
      state_next = bcdo_pkg::ST_PRESET;
      pcnt_next = 32'(bcdo_pkg::PRESET_CYCLES);
      ev_set[bcdo_pkg::EV_TIMEOUT] = 1'b1;
    end
    // Sticky events
    ev_next = ev_reg | ev_set;
    // Register writes
    if (wr_fire)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      case (awaddr_reg)
        bcdo_pkg::ADDR_DATA_OUT:
          if (wstrb_reg[0])
            data_out_next = wdata_reg[7:0];
        bcdo_pkg::ADDR_CTRL2:
          if (wdata_reg != 32'h0 && state_reg == bcdo_pkg::ST_IDLE)
          begin
            req_next = 2'b11;
            ready_next = 1'b0;
            state_next = bcdo_pkg::ST_REQ;
            tcnt_next = 32'h0;
          end
        bcdo_pkg::ADDR_TIMEOUT:
          timeout_next = wdata_reg;
        bcdo_pkg::ADDR_CONFIG:
          edge_sel_next = wdata_reg[1:0];
        bcdo_pkg::ADDR_IRQ_CLR:
          ev_next = (ev_reg & ~wdata_reg[1:0]) | ev_set; // Set wins over clear
        bcdo_pkg::ADDR_IRQ_EN:
          ev_en_next = wdata_reg[1:0];
        default:
          wr_hit = 1'b0;
      endcase
      bresp_next = wr_hit ? bcdo_pkg::RESP_OKAY : bcdo_pkg::RESP_SLVERR;
    end
    // Register reads
    if (rd_fire)
    begin
      rvalid_next = 1'b1;
      rresp_next = bcdo_pkg::RESP_OKAY;
      rdata_next = 32'h0;
      case (s_axi_araddr)
        bcdo_pkg::ADDR_STATUS1: rdata_next[bcdo_pkg::READY_BIT] = ready_reg;
        bcdo_pkg::ADDR_STATUS2: rdata_next[bcdo_pkg::BUSY_BIT] = (state_reg != bcdo_pkg::ST_IDLE);
        bcdo_pkg::ADDR_DATA_OUT: rdata_next = {24'h0, data_out_reg};
        bcdo_pkg::ADDR_LINES: rdata_next = {29'h0, cap_reg.first_sign, cap_reg.second_sign, cap_reg.overrange};
        bcdo_pkg::ADDR_DIGITS: rdata_next = cap_reg.digits[31:0];
        bcdo_pkg::ADDR_DIGITS_HI: rdata_next = {24'h0, cap_reg.digits[39:32]};
        bcdo_pkg::ADDR_TIMEOUT: rdata_next = timeout_reg;
        bcdo_pkg::ADDR_CONFIG: rdata_next = {30'h0, edge_sel_reg};
        bcdo_pkg::ADDR_IRQ_STAT: rdata_next = {30'h0, ev_reg};
        bcdo_pkg::ADDR_IRQ_EN: rdata_next = {30'h0, ev_en_reg};
        default: rresp_next = bcdo_pkg::RESP_SLVERR;
      endcase
    end
  end

  // Register all register, handshake and sequence state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= bcdo_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= bcdo_pkg::RESP_OKAY;
      data_out_reg <= bcdo_pkg::DATA_OUT_RST;
      timeout_reg <= bcdo_pkg::TIMEOUT_RST;
      edge_sel_reg <= 2'h0;
      ready_reg <= 1'b0;
      req_reg <= 2'h0;
      cap_reg <= '0;
      ev_reg <= 2'h0;
      ev_en_reg <= 2'h0;
      tcnt_reg <= 32'h0;
      pcnt_reg <= 32'h0;
      state_reg <= bcdo_pkg::ST_IDLE;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      data_out_reg <= data_out_next;
      timeout_reg <= timeout_next;
      edge_sel_reg <= edge_sel_next;
      ready_reg <= ready_next;
      req_reg <= req_next;
      cap_reg <= cap_next;
      ev_reg <= ev_next;
      ev_en_reg <= ev_en_next;
      tcnt_reg <= tcnt_next;
      pcnt_reg <= pcnt_next;
      state_reg <= state_next;
    end
  end

  // Outputs
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign data_out = data_out_reg;
  assign request_line_a = req_reg[0];
  assign request_line_b = req_reg[1];
  assign peripheral_reset_n = (state_reg != bcdo_pkg::ST_PRESET);
  assign irq = |(ev_reg & ev_en_reg);

  // Cycles spent with the peripheral reset low, for the pulse length check
  logic [31:0] plow_reg, plow_next;
  assign plow_next = peripheral_reset_n ? 32'h0 : plow_reg + 32'h1;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      plow_reg <= 32'h0;
    else
      plow_reg <= plow_next;
  end

  // Assertions
  sequence s_ctrl2_start;
    wr_fire && awaddr_reg == bcdo_pkg::ADDR_CTRL2 && wdata_reg != 32'h0 && state_reg == bcdo_pkg::ST_IDLE;
  endsequence
  a_start_sets_req: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ctrl2_start |=> (req_reg == 2'b11) && !ready_reg) else $error("start failed");
  a_data_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && awaddr_reg == bcdo_pkg::ADDR_DATA_OUT && wstrb_reg[0] |=> data_out == $past(wdata_reg[7:0]))
    else $error("data not latched");
  a_preset_low_min: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(peripheral_reset_n) |-> !peripheral_reset_n [*8]) else $error("reset pulse short");
  a_preset_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(peripheral_reset_n) |-> plow_reg == 32'(bcdo_pkg::PRESET_CYCLES))
    else $error("reset pulse length wrong");
  a_req_clear_after: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(peripheral_reset_n) |-> req_reg == 2'b00) else $error("requests not cleared");
  a_busy_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
    (req_reg != 2'b00) |-> state_reg != bcdo_pkg::ST_IDLE) else $error("busy wrong");
  a_ready_needs_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ready_reg) |-> $past(flag_s2_reg) == 2'b00 && req_reg == 2'b00) else $error("early ready");
  a_timeout_fires: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == bcdo_pkg::ST_REQ || state_reg == bcdo_pkg::ST_WAIT_READY)
    && timeout_reg != 32'h0 && tcnt_reg >= timeout_reg
    |=> state_reg == bcdo_pkg::ST_PRESET) else $error("timeout missed");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ev_reg[0]) && ev_en_reg[0] |-> irq) else $error("irq missing");

endmodule : bcdo_port

// ==== src/bcdo_pkg.sv ====
// Package for the parallel BCD output and handshake port.
// Assumes a 125 MHz aclk and a 32-bit AXI4-Lite register bus.
package bcdo_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_STATUS2 = 8'h0c;
  localparam logic [7:0] ADDR_DATA_OUT = 8'h10;
  localparam logic [7:0] ADDR_LINES = 8'h14;
  localparam logic [7:0] ADDR_DIGITS = 8'h18;
  localparam logic [7:0] ADDR_DIGITS_HI = 8'h1c;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h20;
  localparam logic [7:0] ADDR_CONFIG = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h30;
  // Field positions
  localparam int READY_BIT = 6;
  localparam int BUSY_BIT = 0;
  localparam int EV_READY = 0;
  localparam int EV_TIMEOUT = 1;
  // Reset values and bus response codes
  localparam logic [7:0] DATA_OUT_RST = 8'h00;
  localparam logic [31:0] TIMEOUT_RST = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Peripheral reset pulse, least time
  localparam int CLK_MHZ = 125;
  localparam int PRESET_US = 15;
  localparam int PRESET_CYCLES = PRESET_US * CLK_MHZ;
  // Captured input lines
  typedef struct packed {
    logic [39:0] digits;
    logic first_sign;
    logic second_sign;
    logic overrange;
  } bcdo_inputs_s;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT_READY, ST_PRESET} bcdo_state_e;
endpackage : bcdo_pkg

// ==== bench/bcdo_peer.sv ====
// Peripheral model: answers each request line with one flag pulse.
// Assumes request lines are levels; the port syncs the flags itself.
`timescale 1ns/1ps
module bcdo_peer (
  // Clock
  input wire logic aclk,
  // Port side
  input wire logic [1:0] req,
  input wire logic preset_n,
  output logic [1:0] flag,
  // Bench control
  input wire logic mute,
  input wire logic [7:0] dly
);
  logic [1:0] st [2] = '{2'd0, 2'd0};
  logic [7:0] cnt [2];
  logic [1:0] flag_q = 2'b00;
  // Flags start at ready so the port sees no false edge
  assign flag = flag_q;
  // Per channel: idle, delay to flag, hold flag, wait for request low
  always @(posedge aclk)
    for (int i = 0; i < 2; i++)
    begin
      cnt[i] <= cnt[i] + 8'h01;
      if (!preset_n)
      begin
        st[i] <= 2'd0;
        flag_q[i] <= 1'b0;
      end
      else
        case (st[i])
          2'd0:
            if (req[i] && !mute)
            begin
              st[i] <= 2'd1;
              cnt[i] <= 8'h00;
            end
          2'd1:
            if (cnt[i] == dly)
            begin
              flag_q[i] <= 1'b1;
              st[i] <= 2'd2;
              cnt[i] <= 8'h00;
            end
          2'd2:
            if (cnt[i] == dly)
            begin
              flag_q[i] <= 1'b0;
              st[i] <= 2'd3;
            end
          default:
            if (!req[i])
              st[i] <= 2'd0;
        endcase
    end
endmodule : bcdo_peer

// ==== bench/bcdo_port_bench.sv ====
// Testbench for the BCD output and handshake port.
// Assumes a 125 MHz clock and the peer model on the flag lines.
`timescale 1ns/1ps
module bcdo_port_bench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, req_a, req_b, preset_n, irq, fs, ss, ov, mute;
  logic [7:0] awaddr, araddr, data_out, dly;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, flags, r;
  logic [39:0] digits;
  int fails, n_tests, n;
  typedef struct {logic [7:0] a; logic [31:0] v; logic [31:0] e; logic [1:0] r;} bcdo_row_s;
  bcdo_row_s rows [6] = '{
    '{bcdo_pkg::ADDR_DATA_OUT, 32'h0000005a, 32'h0000005a, bcdo_pkg::RESP_OKAY},
    '{bcdo_pkg::ADDR_CONFIG, 32'h00000003, 32'h00000003, bcdo_pkg::RESP_OKAY},
    '{bcdo_pkg::ADDR_IRQ_EN, 32'h00000003, 32'h00000003, bcdo_pkg::RESP_OKAY},
    '{bcdo_pkg::ADDR_TIMEOUT, 32'h00001234, 32'h00001234, bcdo_pkg::RESP_OKAY},
    '{bcdo_pkg::ADDR_TIMEOUT, 32'h00000000, 32'h00000000, bcdo_pkg::RESP_OKAY},
    '{8'h3c, 32'h00000001, 32'h00000000, bcdo_pkg::RESP_SLVERR}};

  bcdo_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_out(data_out),
    .request_line_a(req_a), .request_line_b(req_b), .peripheral_reset_n(preset_n),
    .peripheral_flag_lines(flags), .digit_inputs(digits), .first_sign_input(fs),
    .second_sign_input(ss), .overrange_input(ov), .irq(irq));
  bcdo_peer peer (.aclk(aclk), .req({req_b, req_a}), .preset_n(preset_n), .flag(flags),
    .mute(mute), .dly(dly));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Bus write; values at the negedge equal those at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    // Only the watchdog ends a wait; bready stays high between calls
    while (!tb)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid === 1'b1;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask : wr

  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    // Only the watchdog ends a wait; rready stays high between calls
    while (!tr)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid === 1'b1;
      v = rdata;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
  endtask : rd

  // Poll the ready indicator under a bound
  task automatic wait_ready();
    int k;
    k = 0;
    d = 32'h0;
    while (d[bcdo_pkg::READY_BIT] !== 1'b1 && k < 100)
    begin
      rd(bcdo_pkg::ADDR_STATUS1, d);
      k++;
    end
    chk("ready", d[bcdo_pkg::READY_BIT], 1);
  endtask : wait_ready

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    results();
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, mute, fs, ss, ov} = '0;
    {awaddr, araddr, wdata, digits} = '0;
    wstrb = 4'hf;
    dly = 8'h08;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("data_out", data_out, 0);
    chk("requests", {req_a, req_b, irq, preset_n}, 1);
    @(posedge aclk);
    rd(bcdo_pkg::ADDR_STATUS2, d);
    chk("busy", d[bcdo_pkg::BUSY_BIT], 0);
    $display("reset test done");
    // Register table rows
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].v, r);
      chk("bresp", r, rows[i].r);
      if (rows[i].r === bcdo_pkg::RESP_OKAY) rd(rows[i].a, d);
      if (rows[i].r === bcdo_pkg::RESP_OKAY) chk("readback", d, rows[i].e);
    end
    chk("data_out", data_out, 8'h5a);
    $display("register test done");
    // Handshakes: leading edge with irq enabled, then trailing edge masked
    for (int i = 0; i < 2; i++)
    begin
      wr(bcdo_pkg::ADDR_CONFIG, i ? 0 : 3, r);
      wr(bcdo_pkg::ADDR_IRQ_EN, i ? 0 : 1, r);
      digits <= {8'h0f, 32'h12345678 + i};
      {fs, ss, ov} <= {i[0], !i[0], 1'b1};
      wr(bcdo_pkg::ADDR_DATA_OUT, 8'hc3 + i, r);
      chk("data_out", data_out, 8'hc3 + i);
      wr(bcdo_pkg::ADDR_CTRL2, 1, r);
      @(negedge aclk);
      chk("req set", {req_a, req_b}, 3);
      @(posedge aclk);
      rd(bcdo_pkg::ADDR_STATUS2, d);
      chk("busy", d[bcdo_pkg::BUSY_BIT], 1);
      rd(bcdo_pkg::ADDR_STATUS1, d);
      chk("ready clr", d[bcdo_pkg::READY_BIT], 0);
      n = 0;
      while (flags[0] !== 1'b1 && n < 50)
      begin
        @(negedge aclk);
        n++;
      end
      repeat (6) @(negedge aclk);
      chk("req edge", req_a, i);
      @(posedge aclk);
      wait_ready();
      chk("req clr", {req_a, req_b, data_out}, 8'hc3 + i);
      rd(bcdo_pkg::ADDR_STATUS2, d);
      chk("busy", d[bcdo_pkg::BUSY_BIT], 0);
      rd(bcdo_pkg::ADDR_DIGITS, d);
      chk("digits", d, 32'h12345678 + i);
      rd(bcdo_pkg::ADDR_DIGITS_HI, d);
      chk("digits hi", d, 32'h0000000f);
      rd(bcdo_pkg::ADDR_LINES, d);
      chk("signs", d[2:0], {i[0], !i[0], 1'b1});
      rd(bcdo_pkg::ADDR_IRQ_STAT, d);
      chk("irq stat", {d[bcdo_pkg::EV_READY], irq}, {1'b1, !i[0]});
      wr(bcdo_pkg::ADDR_IRQ_CLR, 1, r);
      rd(bcdo_pkg::ADDR_IRQ_STAT, d);
      chk("irq clr", {d[bcdo_pkg::EV_READY], irq}, 0);
      $display("handshake test %0d done", i);
    end
    // Zero limit: a silent peripheral is never timed out
    mute <= 1'b1;
    wr(bcdo_pkg::ADDR_CTRL2, 1, r);
    repeat (300) @(negedge aclk);
    chk("no timeout", {preset_n, req_a}, 3);
    @(posedge aclk);
    mute <= 1'b0;
    wait_ready();
    $display("zero limit test done");
    // Timeout after 50 cycles with a silent peripheral
    wr(bcdo_pkg::ADDR_TIMEOUT, 50, r);
    mute <= 1'b1;
    wr(bcdo_pkg::ADDR_CTRL2, 1, r);
    n = 0;
    while (preset_n !== 1'b0 && n < 100)
    begin
      @(negedge aclk);
      n++;
    end
    chk("limit", n >= 44 && n <= 54, 1);
    n = 0;
    while (preset_n !== 1'b1 && n < 3000)
    begin
      @(negedge aclk);
      n++;
    end
    chk("preset len", n >= bcdo_pkg::PRESET_CYCLES, 1);
    chk("req after", {req_a, req_b}, 0);
    @(posedge aclk);
    rd(bcdo_pkg::ADDR_IRQ_STAT, d);
    chk("timeout ev", d[bcdo_pkg::EV_TIMEOUT], 1);
    $display("timeout test done");
    results();
  end
endmodule : bcdo_port_bench
